// ==== verilog/nac_map.svh ====
// Offsets, field positions, codes and timing figures of the association control block.
// Summary of operation
// - End device associates only when role is zero and end-device flag bit 2 set.
// - End-device flag bits allow new network number, new channel, poll on pin wake.
// - End-device flags reset to zero, meaning association off, peer-to-peer.
// - Scan each masked channel: beacon request broadcast, listen fixed time, move on.
// - Flags 0x04: reject beacons differing in network number or channel.
// - Flags 0x05: any network number accepted, channel must match.
// - Flags 0x06: any channel accepted, network number must match.
// - Flags 0x07: accept beacons whatever network number and channel.
// - Among passing beacons pick the one with highest link quality.
// - Indicator steady until joined or formed, then blinks 2 Hz end device, 1 Hz coordinator.
// - Changed association settings while associated cause leaving and rejoining.
// - After joining, destination address takes the joined coordinator's address.
// - Each association sets short source address to 0xfffe.
// - End device ignores coordinator changes; forced disassociation makes it leave and rejoin.
// - Role one forms a network; joins allowed only with coordinator flag bit 2.
// - Coordinator active scan keeps network number unless a beacon matches, then picks new.
// - Without active scan the coordinator forms on its network number regardless of others.
// - Energy scan picks the quietest masked channel, else the fixed channel is used.
// - Both scans: active first, energy skips occupied channels unless all are occupied.
// - Writes to role, network number, coordinator flags or source address re-form the network.
// - Status messages: 0x00 reset, 0x02 associated, 0x03 left or failed, 0x06 formed.
// - Indication codes: 0x00 ok, 0x03, 0x04, 0x05, 0x06, 0x0c, 0x13, 0xff.
`ifndef NAC_MAP_SVH
`define NAC_MAP_SVH

`define NAC_REG_ROLE     4'h0
`define NAC_REG_ED_FLAGS 4'h1
`define NAC_REG_CO_FLAGS 4'h2
`define NAC_REG_SURVEY   4'h3
`define NAC_REG_LANE     4'h4
`define NAC_REG_NET      4'h5
`define NAC_REG_SRC      4'h6
`define NAC_REG_DEST_HI  4'h7
`define NAC_REG_DEST_LO  4'h8
`define NAC_REG_AI       4'h9
`define NAC_REG_DISASSOC 4'ha
`define NAC_REG_STATUS   4'hb

`define NAC_ED_NET_BIT   0
`define NAC_ED_LANE_BIT  1
`define NAC_ED_AUTO_BIT  2
`define NAC_ED_POLL_BIT  3
`define NAC_CO_ASCAN_BIT 0
`define NAC_CO_ESCAN_BIT 1
`define NAC_CO_ALLOW_BIT 2

`define NAC_FLAGS_RST    4'h0
`define NAC_ROLE_CO      1'b1
`define NAC_SRC_LONG     16'hfffe
`define NAC_SRC_RST      16'h0000
`define NAC_NET_RST      16'h3332
`define NAC_NET_BCAST    16'hffff

`define NAC_ST_HW_RESET  8'h00
`define NAC_ST_WDOG      8'h01
`define NAC_ST_ASSOC     8'h02
`define NAC_ST_LEFT      8'h03
`define NAC_ST_FORMED    8'h06
`define NAC_ST_HIGH_VIN  8'h0d

`define NAC_AI_OK        8'h00
`define NAC_AI_NO_ACCEPT 8'h03
`define NAC_AI_BEACONED  8'h04
`define NAC_AI_NET_DIFF  8'h05
`define NAC_AI_LANE_DIFF 8'h06
`define NAC_AI_NO_RESP   8'h0c
`define NAC_AI_LEAVING   8'h13
`define NAC_AI_UNKNOWN   8'hff

`define NAC_CLK_KHZ      25000
`define NAC_LISTEN_US    100
`define NAC_BLINK_ED_MS  250
`define NAC_BLINK_CO_MS  500

`endif

// ==== verilog/nac_pkg.sv ====
// Types shared by the association control block.
package nac_pkg;
	typedef enum logic [3:0] {
		NAC_BOOT,
		NAC_IDLE,
		NAC_SEEK,
		NAC_TX,
		NAC_LISTEN,
		NAC_EREQ,
		NAC_EWAIT,
		NAC_DECIDE,
		NAC_RUN
	} nac_state_t;
endpackage

// ==== verilog/nac_core.sv ====
// Association control: scans, beacon selection, network forming and status reporting.
//
// The placing of the registers and the plain strobed port were decided locally.
`include "nac_map.svh"

module nac_core
	import nac_pkg::*;
#(
	parameter int NLANE     = 16,
	parameter int LISTEN    = (`NAC_LISTEN_US * `NAC_CLK_KHZ) / 1000,
	parameter int BLINK_ED  = `NAC_BLINK_ED_MS * `NAC_CLK_KHZ,
	parameter int BLINK_CO  = `NAC_BLINK_CO_MS * `NAC_CLK_KHZ,
	parameter int LW        = $clog2(NLANE)
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	// Radio scan side
	output logic                   beacon_req,
	output logic                   energy_req,
	output logic      [LW-1:0]     scan_lane,
	input  wire logic              beacon_valid,
	input  wire logic [15:0]       beacon_net,
	input  wire logic [15:0]       beacon_addr_hi,
	input  wire logic [15:0]       beacon_addr_lo,
	input  wire logic [7:0]        beacon_lqi,
	input  wire logic              beacon_permit,
	input  wire logic              beacon_enabled,
	input  wire logic              energy_valid,
	input  wire logic [7:0]        energy_level,
	// Operating settings for the radio
	output logic      [LW-1:0]     op_lane,
	output logic      [15:0]       op_net,
	output logic      [15:0]       op_src,
	output logic                   join_permit,
	output logic                   joined,
	// Sleep side
	input  wire logic              pin_wake,
	output logic                   poll_req,
	// Status
	output logic                   stat_valid,
	output logic      [7:0]        stat_code,
	output logic                   assoc_led
);

	typedef struct packed {
		nac_state_t          state;
		logic                role;
		logic [3:0]          ed_flags;
		logic [2:0]          co_flags;
		logic [NLANE-1:0]    mask;
		logic [LW-1:0]       lane;
		logic [15:0]         net;
		logic [15:0]         src;
		logic [15:0]         dest_hi;
		logic [15:0]         dest_lo;
		logic [7:0]          ai;
		logic [7:0]          last_stat;
		logic [15:0]         rdata;
		logic                escan;
		logic [LW:0]         idx;
		logic [23:0]         cnt;
		logic [23:0]         blink;
		logic                found;
		logic [7:0]          best_q;
		logic [15:0]         best_net;
		logic [LW-1:0]       best_lane;
		logic [15:0]         best_hi;
		logic [15:0]         best_lo;
		logic                clash;
		logic [NLANE-1:0]    busy;
		logic [7:0]          reason;
		logic                joined;
		logic                permit;
		logic                led;
		logic                tx_req;
		logic                ed_req;
		logic [LW-1:0]       scan_lane;
		logic                poll;
		logic                stat_valid;
		logic [7:0]          stat_code;
	} nac_regs_t;

	nac_regs_t r;
	nac_regs_t next_r;
	logic             restart;
	logic             leave;
	logic [NLANE-1:0] active_mask;
	logic [NLANE-1:0] free_mask;
	logic             is_ed;
	logic             net_ok;
	logic             lane_ok;
	logic [LW-1:0]    cur_lane;
	logic [23:0]      blink_top;

	assign is_ed     = (r.role != `NAC_ROLE_CO) && r.ed_flags[`NAC_ED_AUTO_BIT];
	assign cur_lane  = r.idx[LW-1:0];
	assign free_mask = r.mask & ~r.busy;
	assign blink_top = (r.role == `NAC_ROLE_CO) ? 24'(BLINK_CO) : 24'(BLINK_ED);
	assign net_ok  = (beacon_net == r.net) || r.ed_flags[`NAC_ED_NET_BIT];
	assign lane_ok = (cur_lane == r.lane) || r.ed_flags[`NAC_ED_LANE_BIT];

	always_comb begin
		// In the energy scan, occupied lanes are skipped unless that would leave none to measure.
		if (r.escan) begin
			active_mask = (free_mask == '0) ? r.mask : free_mask;
		end else begin
			active_mask = r.mask;
		end
	end

	always_comb begin
		next_r            = r;
		next_r.rdata      = '0;
		next_r.tx_req     = 1'b0;
		next_r.ed_req     = 1'b0;
		next_r.poll       = 1'b0;
		next_r.stat_valid = 1'b0;
		restart           = 1'b0;
		leave             = 1'b0;

		////////////////////////////////////////////////////////////////////////////
		// Register writes. Settings writes other than an end device's source address
		// restart association so the new values take effect; destination writes never disturb a running network.
		if (reg_wr) begin
			case (reg_addr)
				`NAC_REG_ROLE: begin
					next_r.role = reg_wdata[0];
					restart     = 1'b1;
				end
				`NAC_REG_ED_FLAGS: begin
					next_r.ed_flags = reg_wdata[3:0];
					restart         = 1'b1;
				end
				`NAC_REG_CO_FLAGS: begin
					next_r.co_flags = reg_wdata[2:0];
					restart         = 1'b1;
				end
				`NAC_REG_SURVEY: begin
					next_r.mask = reg_wdata[NLANE-1:0];
					restart     = 1'b1;
				end
				`NAC_REG_LANE: begin
					next_r.lane = reg_wdata[LW-1:0];
					restart     = 1'b1;
				end
				`NAC_REG_NET: begin
					next_r.net = reg_wdata;
					restart    = 1'b1;
				end
				`NAC_REG_SRC: begin
					next_r.src = reg_wdata;
					restart    = (r.role == `NAC_ROLE_CO);
				end
				`NAC_REG_DEST_HI: begin
					next_r.dest_hi = reg_wdata;
				end
				`NAC_REG_DEST_LO: begin
					next_r.dest_lo = reg_wdata;
				end
				`NAC_REG_DISASSOC: begin
					restart = 1'b1;
				end
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				`NAC_REG_ROLE:     next_r.rdata = {15'h0000, r.role};
				`NAC_REG_ED_FLAGS: next_r.rdata = {12'h000, r.ed_flags};
				`NAC_REG_CO_FLAGS: next_r.rdata = {13'h0000, r.co_flags};
				`NAC_REG_SURVEY:   next_r.rdata = 16'(r.mask);
				`NAC_REG_LANE:     next_r.rdata = 16'(r.lane);
				`NAC_REG_NET:      next_r.rdata = r.net;
				`NAC_REG_SRC:      next_r.rdata = r.src;
				`NAC_REG_DEST_HI:  next_r.rdata = r.dest_hi;
				`NAC_REG_DEST_LO:  next_r.rdata = r.dest_lo;
				`NAC_REG_AI:       next_r.rdata = {8'h00, r.ai};
				`NAC_REG_STATUS:   next_r.rdata = {8'h00, r.last_stat};
				default:           next_r.rdata = '0;
			endcase
		end

		////////////////////////////////////////////////////////////////////////////
		// Indicator: solid until joined or formed, then a square wave.
		if (!r.joined) begin
			next_r.led   = 1'b1;
			next_r.blink = '0;
		end else if (r.blink >= blink_top - 24'h000001) begin
			next_r.led   = ~r.led;
			next_r.blink = '0;
		end else begin
			next_r.blink = r.blink + 24'h000001;
		end

		////////////////////////////////////////////////////////////////////////////
		case (r.state)
			NAC_BOOT: begin
				next_r.stat_valid = 1'b1;
				next_r.stat_code  = `NAC_ST_HW_RESET;
				next_r.last_stat  = `NAC_ST_HW_RESET;
				next_r.state      = NAC_IDLE;
			end
			NAC_IDLE: begin
				next_r.idx     = '0;
				next_r.found   = 1'b0;
				next_r.best_q  = '0;
				next_r.clash   = 1'b0;
				next_r.busy    = '0;
				next_r.escan   = 1'b0;
				next_r.reason  = `NAC_AI_NO_RESP;
				next_r.joined  = 1'b0;
				next_r.permit  = 1'b0;
				if (r.role != `NAC_ROLE_CO) begin
					if (is_ed) begin
						next_r.ai    = `NAC_AI_UNKNOWN;
						next_r.src   = `NAC_SRC_LONG;
						next_r.state = NAC_SEEK;
					end else begin
						next_r.ai    = `NAC_AI_OK;
						next_r.state = NAC_RUN;
					end
				end else begin
					next_r.ai = `NAC_AI_UNKNOWN;
					if (r.co_flags[`NAC_CO_ASCAN_BIT]) begin
						next_r.state = NAC_SEEK;
					end else begin
						next_r.escan = 1'b1;
						next_r.state = r.co_flags[`NAC_CO_ESCAN_BIT] ? NAC_SEEK
							: NAC_DECIDE;
					end
				end
			end
			NAC_SEEK: begin
				if (r.idx == (LW+1)'(NLANE)) begin
					next_r.state = NAC_DECIDE;
				end else if (active_mask[cur_lane]) begin
					next_r.scan_lane = cur_lane;
					next_r.state     = r.escan ? NAC_EREQ : NAC_TX;
				end else begin
					next_r.idx = r.idx + (LW+1)'(1);
				end
			end
			NAC_TX: begin
				next_r.tx_req = 1'b1;
				next_r.cnt    = 24'(LISTEN);
				next_r.state  = NAC_LISTEN;
			end
			NAC_LISTEN: begin
				if (beacon_valid) begin
					next_r.busy[cur_lane] = 1'b1;
					if (beacon_net == r.net) begin
						next_r.clash = 1'b1;
					end
					if (beacon_enabled) begin
						next_r.reason = `NAC_AI_BEACONED;
					end else if (!net_ok) begin
						next_r.reason = `NAC_AI_NET_DIFF;
					end else if (!lane_ok) begin
						next_r.reason = `NAC_AI_LANE_DIFF;
					end else if (!beacon_permit) begin
						next_r.reason = `NAC_AI_NO_ACCEPT;
					end else if (!r.found || beacon_lqi > r.best_q) begin
						next_r.found     = 1'b1;
						next_r.best_q    = beacon_lqi;
						next_r.best_net  = beacon_net;
						next_r.best_lane = cur_lane;
						next_r.best_hi   = beacon_addr_hi;
						next_r.best_lo   = beacon_addr_lo;
					end
				end
				if (r.cnt <= 24'h000001) begin
					next_r.idx   = r.idx + (LW+1)'(1);
					next_r.state = NAC_SEEK;
				end else begin
					next_r.cnt = r.cnt - 24'h000001;
				end
			end
			NAC_EREQ: begin
				next_r.ed_req = 1'b1;
				next_r.state  = NAC_EWAIT;
			end
			NAC_EWAIT: begin
				if (energy_valid) begin
					if (!r.found || energy_level < r.best_q) begin
						next_r.found     = 1'b1;
						next_r.best_q    = energy_level;
						next_r.best_lane = cur_lane;
					end
					next_r.idx   = r.idx + (LW+1)'(1);
					next_r.state = NAC_SEEK;
				end
			end
			NAC_DECIDE: begin
				if (r.role != `NAC_ROLE_CO) begin
					if (r.found) begin
						next_r.net       = r.best_net;
						next_r.lane      = r.best_lane;
						next_r.dest_hi   = r.best_hi;
						next_r.dest_lo   = r.best_lo;
						next_r.src       = `NAC_SRC_LONG;
						next_r.joined    = 1'b1;
						next_r.ai        = `NAC_AI_OK;
						next_r.stat_code = `NAC_ST_ASSOC;
						next_r.last_stat = `NAC_ST_ASSOC;
						next_r.state     = NAC_RUN;
					end else begin
						next_r.ai        = r.reason;
						next_r.stat_code = `NAC_ST_LEFT;
						next_r.last_stat = `NAC_ST_LEFT;
						next_r.state     = NAC_IDLE;
					end
					next_r.stat_valid = 1'b1;
				end else if (!r.escan) begin
					// Active scan done: move off a number already in use.
					if (r.clash) begin
						next_r.net = (r.net + 16'h0001 == `NAC_NET_BCAST) ? 16'h0000
							: r.net + 16'h0001;
					end
					next_r.escan  = 1'b1;
					next_r.found  = 1'b0;
					next_r.idx    = '0;
					next_r.state  = r.co_flags[`NAC_CO_ESCAN_BIT] ? NAC_SEEK
						: NAC_DECIDE;
				end else if (r.co_flags[`NAC_CO_ESCAN_BIT] && !r.found) begin
					next_r.stat_valid = 1'b1;
					next_r.stat_code  = `NAC_ST_LEFT;
					next_r.last_stat  = `NAC_ST_LEFT;
					next_r.state      = NAC_RUN;
				end else begin
					if (r.co_flags[`NAC_CO_ESCAN_BIT]) begin
						next_r.lane = r.best_lane;
					end
					next_r.joined     = 1'b1;
					next_r.permit     = r.co_flags[`NAC_CO_ALLOW_BIT];
					next_r.ai         = `NAC_AI_OK;
					next_r.stat_valid = 1'b1;
					next_r.stat_code  = `NAC_ST_FORMED;
					next_r.last_stat  = `NAC_ST_FORMED;
					next_r.state      = NAC_RUN;
				end
			end
			NAC_RUN: begin
				if (r.joined && r.role != `NAC_ROLE_CO && pin_wake
					&& r.ed_flags[`NAC_ED_POLL_BIT]) begin
					next_r.poll = 1'b1;
				end
			end
			default: begin
				next_r.state = NAC_IDLE;
			end
		endcase

		////////////////////////////////////////////////////////////////////////////
		// A settings change wins over the scan in progress. An associated end
		// device reports its leaving before it scans again.
		if (restart && r.state != NAC_BOOT) begin
			leave           = r.joined && r.role != `NAC_ROLE_CO;
			next_r.state    = NAC_IDLE;
			next_r.joined   = 1'b0;
			next_r.permit   = 1'b0;
			if (leave) begin
				next_r.ai         = `NAC_AI_LEAVING;
				next_r.stat_valid = 1'b1;
				next_r.stat_code  = `NAC_ST_LEFT;
				next_r.last_stat  = `NAC_ST_LEFT;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r          <= '0;
			r.state    <= NAC_BOOT;
			r.ed_flags <= `NAC_FLAGS_RST;
			r.co_flags <= 3'(`NAC_FLAGS_RST);
			r.mask     <= '1;
			r.net      <= `NAC_NET_RST;
			r.src      <= `NAC_SRC_RST;
			r.ai       <= `NAC_AI_UNKNOWN;
			r.led      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata   = r.rdata;
	assign beacon_req  = r.tx_req;
	assign energy_req  = r.ed_req;
	assign scan_lane   = r.scan_lane;
	assign op_lane     = r.lane;
	assign op_net      = r.net;
	assign op_src      = r.src;
	assign join_permit = r.permit;
	assign joined      = r.joined;
	assign poll_req    = r.poll;
	assign stat_valid  = r.stat_valid;
	assign stat_code   = r.stat_code;
	assign assoc_led   = r.led;

endmodule // nac_core

// ==== verilog/nac_core_end.sv ====
// Spare design file: all association logic lives in the core module.

// ==== tb/nac_core_properties.sv ====
// Port-level assertions for the association control block.
module nac_core_properties #(
	parameter int LISTEN = 8
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        beacon_req,
	input wire logic        energy_req,
	input wire logic        pin_wake,
	input wire logic [15:0] op_src,
	input wire logic        join_permit,
	input wire logic        joined,
	input wire logic        poll_req,
	input wire logic        stat_valid,
	input wire logic [7:0]  stat_code,
	input wire logic        assoc_led
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] gap;
	// A register write may restart the scan at any lane, so it voids the spacing check.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			gap <= 8'hff;
		else if (reg_wr)
			gap <= 8'hff;
		else if (beacon_req)
			gap <= 8'h00;
		else if (gap != 8'hff)
			gap <= gap + 8'h01;
	end
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_bcn_once;
		beacon_req ##1 !beacon_req;
	endsequence
	sequence s_assoc_msg;
		stat_valid && stat_code == 8'h02;
	endsequence
	////////////////////////////////////////////////////////////
	a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_beacon_single: assert property (beacon_req |-> s_bcn_once)
		else $error("beacon request longer than one cycle");
	a_energy_single: assert property (energy_req |=> !energy_req)
		else $error("energy request longer than one cycle");
	a_listen_gap: assert property (beacon_req |-> gap >= LISTEN + 1)
		else $error("beacon request before the listen time ran out");
	a_poll_cause: assert property (poll_req |-> $past(pin_wake) && $past(joined))
		else $error("poll without pin wake while joined");
	a_led_solid: assert property (!joined && !$past(joined) |-> assoc_led)
		else $error("indicator not steady before joining");
	a_permit_formed: assert property (join_permit |-> joined)
		else $error("joins permitted without a formed network");
	a_boot_message: assert property ($fell(rst) |=> stat_valid && stat_code == 8'h00)
		else $error("no reset status message after reset");
	a_status_held: assert property ($changed(stat_code) |-> stat_valid)
		else $error("status code changed without a message");
	a_assoc_long_src: assert property (s_assoc_msg |-> joined && op_src == 16'hfffe)
		else $error("associated without long source address");
endmodule // nac_core_properties

bind nac_core nac_core_properties #(.LISTEN(LISTEN)) nac_core_properties_inst (
	.mclk, .rst, .reg_wr, .reg_rd, .reg_rdata, .beacon_req, .energy_req, .pin_wake, .op_src,
	.join_permit, .joined, .poll_req, .stat_valid, .stat_code, .assoc_led
);

// ==== tb/nac_radio_model.sv ====
// Behavioural radio neighbourhood answering beacon requests and energy probes.
module nac_radio_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Requests from the block
	input  wire logic        beacon_req,
	input  wire logic        energy_req,
	input  wire logic [3:0]  scan_lane,
	// Answers to the block
	output logic             beacon_valid,
	output logic      [15:0] beacon_net,
	output logic      [15:0] beacon_addr_hi,
	output logic      [15:0] beacon_addr_lo,
	output logic      [7:0]  beacon_lqi,
	output logic             beacon_permit,
	output logic             beacon_enabled,
	output logic             energy_valid,
	output logic      [7:0]  energy_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        on  [16];
	logic [15:0] net [16];
	logic [7:0]  lqi [16];
	logic [7:0]  eng [16];
	logic        hit;
	assign hit = beacon_req && on[scan_lane];
	// Idle answer lines other than the two valid strobes carry the inverse of their last value so stale data never looks fresh.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			beacon_valid <= 1'b0;
			beacon_net <= 16'h0000;
			beacon_addr_hi <= 16'h0000;
			beacon_addr_lo <= 16'h0000;
			beacon_lqi <= 8'h00;
			beacon_permit <= 1'b0;
			beacon_enabled <= 1'b0;
			energy_valid <= 1'b0;
			energy_level <= 8'h00;
		end else begin
			beacon_valid <= hit;
			beacon_net <= hit ? net[scan_lane] : ~beacon_net;
			beacon_addr_hi <= hit ? {12'h0a0, scan_lane} : ~beacon_addr_hi;
			beacon_addr_lo <= hit ? {12'hb00, scan_lane} : ~beacon_addr_lo;
			beacon_lqi <= hit ? lqi[scan_lane] : ~beacon_lqi;
			beacon_permit <= hit ? 1'b1 : ~beacon_permit;
			beacon_enabled <= hit ? 1'b0 : ~beacon_enabled;
			energy_valid <= energy_req;
			energy_level <= energy_req ? eng[scan_lane] : ~energy_level;
		end
	end
endmodule // nac_radio_model

// ==== tb/nac_core_bench.sv ====
// Self-checking bench for the association control block.
`include "nac_map.svh"

module nac_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LISTEN = 8;
	localparam int BLINK_ED = 10;
	localparam int BLINK_CO = 20;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pin_wake = 1'b0;
	logic [15:0] reg_rdata, beacon_net, beacon_addr_hi, beacon_addr_lo, op_net, op_src;
	logic [7:0]  beacon_lqi, energy_level, stat_code;
	logic [3:0]  scan_lane, op_lane;
	logic        beacon_req, energy_req, beacon_valid, beacon_permit, beacon_enabled;
	logic        energy_valid, join_permit, joined, poll_req, stat_valid, assoc_led;
	logic [15:0] bnet [1:3] = '{16'h3332, 16'h1111, 16'h5555};
	logic [7:0]  blqi [1:3] = '{8'h5a, 8'h32, 8'h63};
	logic [7:0]  beng [1:4] = '{8'h1e, 8'h0a, 8'h14, 8'h28};
	logic [3:0]  xln [5:7] = '{4'h2, 4'h1, 4'h3};
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	nac_core #(.LISTEN(LISTEN), .BLINK_ED(BLINK_ED), .BLINK_CO(BLINK_CO)) nac_core_inst (
		.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .beacon_req,
		.energy_req, .scan_lane, .beacon_valid, .beacon_net, .beacon_addr_hi, .beacon_addr_lo,
		.beacon_lqi, .beacon_permit, .beacon_enabled, .energy_valid, .energy_level, .op_lane,
		.op_net, .op_src, .join_permit, .joined, .pin_wake, .poll_req, .stat_valid,
		.stat_code, .assoc_led
	);
	nac_radio_model nac_radio_model_inst (
		.mclk, .rst, .beacon_req, .energy_req, .scan_lane, .beacon_valid, .beacon_net,
		.beacon_addr_hi, .beacon_addr_lo, .beacon_lqi, .beacon_permit, .beacon_enabled,
		.energy_valid, .energy_level
	);

	always #20 mclk = ~mclk;
	// The whole run needs a few hundred cycles; anything far beyond that is a hang.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		check(what, reg_rdata, exp);
	endtask
	task automatic wait_stat(input logic [7:0] code);
		int i;
		i = 0;
		// Look only at settled values, never in the time step of the launching edge.
		@(negedge mclk);
		while (!(stat_valid === 1'b1 && stat_code === code) && i < 1000) begin
			@(negedge mclk);
			i++;
		end
		check("status", {stat_valid, 7'h00, stat_code}, {1'b1, 7'h00, code});
	endtask
	task automatic blink(input int per);
		logic l;
		int i;
		for (int k = 0; k < 2; k++) begin
			l = assoc_led;
			i = 0;
			while (assoc_led === l && i < 100) begin
				@(negedge mclk);
				i++;
			end
		end
		check("blink", i[15:0], per[15:0]);
	endtask
	task automatic poll(input logic exp);
		@(posedge mclk);
		pin_wake <= 1'b1;
		repeat (2) @(negedge mclk);
		check("poll", {15'h0000, poll_req}, {15'h0000, exp});
		@(posedge mclk);
		pin_wake <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 16; i++) begin
			nac_radio_model_inst.on[i] = (i > 0 && i < 4);
			nac_radio_model_inst.eng[i] = 8'h80;
		end
		for (int i = 1; i < 4; i++) begin
			nac_radio_model_inst.net[i] = bnet[i];
			nac_radio_model_inst.lqi[i] = blqi[i];
		end
		for (int i = 1; i < 5; i++)
			nac_radio_model_inst.eng[i] = beng[i];
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(`NAC_REG_ROLE, 16'h0000, "role");
		rd(`NAC_REG_ED_FLAGS, 16'h0000, "ed flags");
		rd(`NAC_REG_CO_FLAGS, 16'h0000, "co flags");
		rd(4'hc, 16'h0000, "unmapped");
		wr(`NAC_REG_AI, 16'h0055);
		rd(`NAC_REG_AI, 16'h0000, "ai");
		check("led", {15'h0000, assoc_led}, 16'h0001);
		wr(`NAC_REG_SURVEY, 16'h000e);
		for (int m = 4; m < 8; m++) begin
			wr(`NAC_REG_LANE, 16'h0002);
			if (m > 5) begin
				@(negedge mclk);
				check("left", {joined, 7'h00, stat_code}, 16'h0003);
			end
			wr(`NAC_REG_NET, 16'h3332);
			wr(`NAC_REG_ED_FLAGS, m[15:0]);
			if (m == 4) begin
				wait_stat(`NAC_ST_LEFT);
			end else begin
				wait_stat(`NAC_ST_ASSOC);
				check("net", op_net, bnet[xln[m]]);
				check("lane", {12'h000, op_lane}, {12'h000, xln[m]});
				check("src", op_src, `NAC_SRC_LONG);
				rd(`NAC_REG_DEST_HI, {12'h0a0, xln[m]}, "dest hi");
				rd(`NAC_REG_DEST_LO, {12'hb00, xln[m]}, "dest lo");
			end
		end
		blink(BLINK_ED);
		poll(1'b0);
		wr(`NAC_REG_ED_FLAGS, 16'h000f);
		wait_stat(`NAC_ST_ASSOC);
		poll(1'b1);
		wr(`NAC_REG_DISASSOC, 16'h0001);
		@(negedge mclk);
		check("drop", {joined, 7'h00, stat_code}, 16'h0003);
		wait_stat(`NAC_ST_ASSOC);
		rd(`NAC_REG_AI, 16'h0000, "ai");
		wr(`NAC_REG_SURVEY, 16'h001e);
		wr(`NAC_REG_NET, 16'h3332);
		wr(`NAC_REG_CO_FLAGS, 16'h0007);
		wr(`NAC_REG_ROLE, 16'h0001);
		wait_stat(`NAC_ST_FORMED);
		check("co net", op_net, 16'h3333);
		check("co lane", {12'h000, op_lane}, 16'h0004);
		check("permit", {15'h0000, join_permit}, 16'h0001);
		rd(`NAC_REG_STATUS, {8'h00, `NAC_ST_FORMED}, "last stat");
		blink(BLINK_CO);
		wr(`NAC_REG_LANE, 16'h0007);
		wr(`NAC_REG_NET, 16'h3332);
		wr(`NAC_REG_CO_FLAGS, 16'h0000);
		wait_stat(`NAC_ST_FORMED);
		check("fixed net", op_net, 16'h3332);
		check("fixed lane", {12'h000, op_lane}, 16'h0007);
		check("no permit", {15'h0000, join_permit}, 16'h0000);
		wr(`NAC_REG_SRC, 16'h0042);
		@(negedge mclk);
		check("reform", {15'h0000, joined}, 16'h0000);
		wait_stat(`NAC_ST_FORMED);
		check("co src", op_src, 16'h0042);
		results();
	end
endmodule // nac_core_bench
